// >>> dv/pdmae_engine_tb_top.sv
// Testbench: registers, sized transfers, reload, priority, fault and disable
`timescale 1ns/1ps
module pdmae_engine_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, periph_wstrobe, mem_valid, mem_done, mem_error;
  logic [11:0] paddr = 12'h000;
  logic [11:0] irq_lines;
  logic [31:0] pwdata = 32'h0000_0000, periph_rdata = 32'h0000_0000, lfsr_q = 32'h0000_3b51;
  logic [31:0] prdata, periph_addr, periph_wdata, mem_rdata;
  logic [7:0] periph_req, periph_ack, want = 8'h00, to_mem = 8'h3f;
  logic [255:0] hold_addr = 256'h0;
  pdmae_pkg::pdmae_mem_req_t mem_req;
  logic [63:0] notes[$];
  logic [1:0] sizes[$];
  int failures = 0, samples_checked = 0, acks = 0, cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  pdmae_engine #(.CHANNELS(4), .PERIPHS(8), .ID_BITS(3)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .periph_ack(periph_ack),
    .periph_to_mem(to_mem), .periph_holding_addr(hold_addr), .periph_addr(periph_addr),
    .periph_wdata(periph_wdata), .periph_wstrobe(periph_wstrobe), .periph_rdata(periph_rdata),
    .mem_req(mem_req), .mem_valid(mem_valid), .mem_done(mem_done), .mem_error(mem_error),
    .mem_rdata(mem_rdata), .irq_lines(irq_lines));

  pdmae_partner #(.PERIPHS(8)) partner (.clk_sys(clk_sys), .reset_n(reset_n), .want(want),
    .periph_ack(periph_ack), .periph_req(periph_req), .mem_req(mem_req), .mem_valid(mem_valid),
    .mem_done(mem_done), .mem_error(mem_error), .mem_rdata(mem_rdata));

  task print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  function automatic logic [31:0] stp(input logic [1:0] s);
    return s == 2'h0 ? pdmae_pkg::STEP_BYTE : s == 2'h1 ? pdmae_pkg::STEP_HALF : pdmae_pkg::STEP_WORD;
  endfunction

  function automatic logic [31:0] msk(input logic [1:0] s);
    return s == 2'h0 ? pdmae_pkg::MASK_BYTE : s == 2'h1 ? pdmae_pkg::MASK_HALF : pdmae_pkg::MASK_WORD;
  endfunction

  // APB cycle: setup, access until pready, then release and let one edge pass
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      notes.push_back({32'h0000_0000, exp});
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    check({63'h0, pslverr}, {63'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task wr(input int c, input logic [5:0] o, input logic [31:0] d);
    apb(1'b1, {6'(c), o}, d, 32'h0000_0000, 1'b0);
  endtask

  task rd(input int c, input logic [5:0] o, input logic [31:0] exp);
    apb(1'b0, {6'(c), o}, 32'h0000_0000, exp, 1'b0);
  endtask

  task wait_acks(input int n);
    int t;
    t = acks + n;
    for (int i = 0; i < 500 && acks < t; i++)
      @(posedge clk_sys);
    check(64'(acks), 64'(t));
  endtask

  // Expected item and the memory access size it must use
  task note(input logic [63:0] v, input logic [1:0] s);
    notes.push_back(v);
    sizes.push_back(s);
  endtask

  task take(input logic [63:0] seen);
    if (notes.size() == 0)
      check(seen, {64{1'bz}});
    else
      check(seen, notes.pop_front());
  endtask

  // Results: read data, memory writes and holding register writes
  always @(posedge clk_sys)
  begin
    if (reset_n)
    begin
      cycles++;
      acks += $countones(periph_ack);
      if (psel && penable && pready && !pwrite)
        take({32'h0000_0000, prdata});
      if (mem_valid && mem_done && mem_req.write)
        take({mem_req.addr, mem_req.wdata});
      if (mem_valid && (mem_done || mem_error))
        check({62'h0, mem_req.size}, {62'h0, (sizes.size() == 0 ? 2'h3 : sizes.pop_front())});
      if (periph_wstrobe)
        take({periph_addr, periph_wdata});
      if (cycles > 20000)
      begin
        failures++;
        print_verdict();
      end
    end
  end

  initial
  begin
    logic [31:0] p, q, d;
    logic [1:0] s;
    logic [2:0] id;
    for (int i = 0; i < 8; i++)
      hold_addr[i*32+:32] = 32'h4000_0000 + 32'(i * 16);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, read-only and unmapped places
    for (int o = 0; o < 44; o += 4)
      if (o != 20 && o != 32 && o != 36)
        rd(0, 6'(o), 32'h0000_0000);
    wr(3, pdmae_pkg::OFS_STATE, 32'h0000_0001);
    rd(3, pdmae_pkg::OFS_STATE, 32'h0000_0000);
    apb(1'b1, 12'h100, 32'h0000_0001, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h100, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h002, 32'h0000_0000, 32'h0000_0000, 1'b1);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      s = (c == 3) ? 2'h1 : 2'(c);
      id = (c == 3) ? 3'h6 : 3'(c);
      p = rnd() & 32'h0fff_fffc;
      d = rnd();
      periph_rdata <= d;
      wr(c, pdmae_pkg::OFS_SELECT, 32'(id));
      wr(c, pdmae_pkg::OFS_MODE, 32'(s));
      wr(c, pdmae_pkg::OFS_POINTER, p);
      wr(c, pdmae_pkg::OFS_INT_SET, 32'h0000_0002);
      wr(c, pdmae_pkg::OFS_CONTROL, 32'h0000_0001);
      wr(c, pdmae_pkg::OFS_COUNT, 32'h0000_0003);
      for (int i = 0; i < 3; i++)
      begin
        q = p + 32'(i) * stp(s);
        note(c == 3 ? {hold_addr[223:192], ~q & msk(s)} : {q, d & msk(s)}, s);
      end
      want[id] <= 1'b1;
      wait_acks(3);
      want <= 8'h00;
      check({63'h0, irq_lines[c*3+1]}, 64'h1);
      rd(c, pdmae_pkg::OFS_POINTER, p + 32'h3 * stp(s));
      rd(c, pdmae_pkg::OFS_COUNT, 32'h0000_0000);
      rd(c, pdmae_pkg::OFS_INT_STATUS, 32'h0000_0003);
      rd(c, pdmae_pkg::OFS_STATE, 32'h0000_0001);
      $display("test size %0d done", c);
    end
    // reload write with zero count loads at once
    p = rnd() & 32'h0fff_fffc;
    q = p + 32'h0000_0100;
    wr(0, pdmae_pkg::OFS_POINTER_RELOAD, p);
    wr(0, pdmae_pkg::OFS_COUNT_RELOAD, 32'h0000_0002);
    rd(0, pdmae_pkg::OFS_POINTER, p);
    rd(0, pdmae_pkg::OFS_COUNT, 32'h0000_0002);
    wr(0, pdmae_pkg::OFS_POINTER_RELOAD, q);
    wr(0, pdmae_pkg::OFS_COUNT_RELOAD, 32'h0000_0001);
    rd(0, pdmae_pkg::OFS_INT_STATUS, 32'h0000_0000);
    // second buffer follows without a gap
    note({p, d & pdmae_pkg::MASK_BYTE}, 2'h0);
    note({p + 32'h1, d & pdmae_pkg::MASK_BYTE}, 2'h0);
    note({q, d & pdmae_pkg::MASK_BYTE}, 2'h0);
    want[0] <= 1'b1;
    wait_acks(3);
    want <= 8'h00;
    rd(0, pdmae_pkg::OFS_POINTER, q + 32'h1);
    rd(0, pdmae_pkg::OFS_POINTER_RELOAD, 32'h0000_0000);
    rd(0, pdmae_pkg::OFS_COUNT_RELOAD, 32'h0000_0000);
    $display("test reload done");
    // both request together, lower channel first
    p = rnd() & 32'h0fff_fffc;
    q = rnd() & 32'h0fff_fffc;
    wr(2, pdmae_pkg::OFS_POINTER, q);
    wr(2, pdmae_pkg::OFS_COUNT, 32'h0000_0001);
    wr(1, pdmae_pkg::OFS_POINTER, p);
    wr(1, pdmae_pkg::OFS_COUNT, 32'h0000_0001);
    note({p, d & pdmae_pkg::MASK_HALF}, 2'h1);
    note({q, d}, 2'h2);
    want <= 8'h06;
    wait_acks(2);
    want <= 8'h00;
    $display("test priority done");
    wr(0, pdmae_pkg::OFS_INT_SET, 32'h0000_0004);
    wr(0, pdmae_pkg::OFS_POINTER, 32'hf000_0000);
    wr(0, pdmae_pkg::OFS_COUNT, 32'h0000_0002);
    sizes.push_back(2'h0);
    want[0] <= 1'b1;
    for (int i = 0; i < 40 && irq_lines[2] !== 1'b1; i++)
      @(posedge clk_sys);
    check({63'h0, irq_lines[2]}, 64'h1);
    repeat (20) @(posedge clk_sys);
    rd(0, pdmae_pkg::OFS_INT_STATUS, 32'h0000_0005);
    // pointer fixed before the fault is cleared
    p = rnd() & 32'h0fff_fffc;
    wr(0, pdmae_pkg::OFS_POINTER, p);
    note({p, d & pdmae_pkg::MASK_BYTE}, 2'h0);
    note({p + 32'h1, d & pdmae_pkg::MASK_BYTE}, 2'h0);
    wr(0, pdmae_pkg::OFS_CONTROL, 32'h0000_0100);
    wait_acks(2);
    want <= 8'h00;
    check({63'h0, irq_lines[2]}, 64'h0);
    $display("test fault done");
    wr(1, pdmae_pkg::OFS_CONTROL, 32'h0000_0002);
    rd(1, pdmae_pkg::OFS_STATE, 32'h0000_0000);
    wr(1, pdmae_pkg::OFS_POINTER, p);
    wr(1, pdmae_pkg::OFS_COUNT, 32'h0000_0001);
    want[1] <= 1'b1;
    repeat (20) @(posedge clk_sys);
    note({p, d & pdmae_pkg::MASK_HALF}, 2'h1);
    wr(1, pdmae_pkg::OFS_CONTROL, 32'h0000_0001);
    wait_acks(1);
    want <= 8'h00;
    check({63'h0, irq_lines[4]}, 64'h1);
    wr(1, pdmae_pkg::OFS_INT_CLEAR, 32'h0000_0002);
    rd(1, pdmae_pkg::OFS_INT_MASK, 32'h0000_0000);
    check({63'h0, irq_lines[4]}, 64'h0);
    $display("test disable and mask done");
    print_verdict();
  end
endmodule

// >>> dv/pdmae_partner.sv
// Partner model: memory slave and request sources of the peripherals
`timescale 1ns/1ps
module pdmae_partner #(
  parameter int unsigned PERIPHS = 8
) (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [PERIPHS-1:0] want, // Peripherals with items pending
  input wire logic [PERIPHS-1:0] periph_ack, // Acknowledge pulses
  output logic [PERIPHS-1:0] periph_req, // Request levels
  input wire pdmae_pkg::pdmae_mem_req_t mem_req, // Memory request
  input wire logic mem_valid, // Request valid
  output logic mem_done, // Access finished
  output logic mem_error, // Access failed
  output logic [31:0] mem_rdata // Read data
);
  logic [1:0] wait_cnt;
  logic slow;
  assign periph_req = want & ~periph_ack;
  // Alternate prompt and slow answers; top region is unmapped
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      mem_done <= 1'b0;
      mem_error <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end
    else
    begin
      mem_done <= 1'b0;
      mem_error <= 1'b0;
      // Stale read data keeps moving so it is never mistaken for fresh data
      mem_rdata <= mem_rdata + 32'h3779_b9c1;
      if (mem_valid && !mem_done && !mem_error)
      begin
        if (wait_cnt == {slow, 1'b0})
        begin
          wait_cnt <= 2'h0;
          slow <= ~slow;
          if (mem_req.addr[31:28] == 4'hf)
            mem_error <= 1'b1;
          else
          begin
            mem_done <= 1'b1;
            mem_rdata <= ~mem_req.addr;
          end
        end
        else
          wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

// >>> rtl/pdmae_arbiter.sv
// Fixed-priority arbiter, lowest index wins
`timescale 1ns/1ps
module pdmae_arbiter #(
  parameter int unsigned N = 4
) (
  input wire logic [N-1:0] request, // Eligible channel requests
  output logic [N-1:0] grant, // One-hot grant
  output logic any // Any request present
);
  logic [N:0] blocked;
  assign blocked[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pri
      assign grant[g] = request[g] & ~blocked[g];
      assign blocked[g+1] = blocked[g] | request[g];
    end
  endgenerate
  assign any = blocked[N];
endmodule

// >>> rtl/pdmae_engine.sv
// Peripheral DMA engine: channel registers, APB slave, arbitration, transfer engine
// Functional notes
// - Count zero, reload non-zero: reload pointer and count
// - After reload clear both reload registers
// - Reload write while count zero loads live
// - Identity selects direction, handshake, holding address
// - Per-channel byte, halfword or word size
// - Memory access uses configured size
// - Peripheral data zeroed above item width
// - Enable/disable bits; state readable
// - Serve requests while count non-zero
// - Mask set/clear registers; mask, status readable
// - Reload-empty, done and fault sources
// - Lowest-numbered requesting channel served first
// - Memory error sets fault, stops channel
// - Each channel occupies a 0x040-byte window
// - Pointer holds next memory address
// - Sixteen-bit count shows items remaining
// - Identity field width is a parameter
// - Count decrements after each item
// - Pointer advances by one, two or four
// - Non-zero count write starts transfers
// - Acknowledge request once item transfer completed
`timescale 1ns/1ps
module pdmae_engine #(
  parameter int unsigned CHANNELS = 4,
  parameter int unsigned PERIPHS = 8,
  parameter int unsigned ID_BITS = 3,
  parameter logic [7:0] SELECT_RESET = 8'h00 // Arbitrary reset identity
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [PERIPHS-1:0] periph_req, // Peripheral requests
  output logic [PERIPHS-1:0] periph_ack, // Peripheral acknowledges
  input wire logic [PERIPHS-1:0] periph_to_mem, // Direction per identity: 1 peripheral to memory
  input wire logic [PERIPHS*32-1:0] periph_holding_addr, // Holding register address per identity
  output logic [31:0] periph_addr, // Holding address of active transfer
  output logic [31:0] periph_wdata, // Data to peripheral
  output logic periph_wstrobe, // Write holding register
  input wire logic [31:0] periph_rdata, // Data from peripheral
  output pdmae_pkg::pdmae_mem_req_t mem_req, // Memory request fields
  output logic mem_valid, // Memory request valid
  input wire logic mem_done, // Memory access finished
  input wire logic mem_error, // Memory access failed
  input wire logic [31:0] mem_rdata, // Memory read data
  output logic [CHANNELS*3-1:0] irq_lines // Per channel masked interrupt sources
);
  localparam int unsigned CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

  typedef struct packed {
    pdmae_pkg::pdmae_chan_t [CHANNELS-1:0] ch;
    pdmae_pkg::pdmae_state_t state;
    logic [CW-1:0] cur;
    logic [31:0] data;
    logic [31:0] prdata;
    logic [PERIPHS-1:0] ack;
  } pdmae_all_t;

  pdmae_all_t s_reg, s_next;

  // ======================================================
  // Decode and arbitration
  logic [CHANNELS-1:0] eligible, grant;
  logic grant_any;
  logic [CW-1:0] grant_idx;
  logic acc;
  logic [5:0] ofs;
  logic [11-pdmae_pkg::CHAN_STRIDE_BITS:0] chsel;
  logic ch_hit;
  logic [2:0] src [CHANNELS];

  assign ofs = paddr[pdmae_pkg::CHAN_STRIDE_BITS-1:0];
  assign chsel = paddr[11:pdmae_pkg::CHAN_STRIDE_BITS];
  assign ch_hit = (32'(chsel) < CHANNELS) && (paddr[1:0] == 2'b00);
  assign acc = psel & penable;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      logic [ID_BITS-1:0] id;
      assign id = s_reg.ch[g].select[ID_BITS-1:0];
      assign src[g][pdmae_pkg::INT_RELOAD_EMPTY] = s_reg.ch[g].count_reload == pdmae_pkg::ZERO_COUNT;
      assign src[g][pdmae_pkg::INT_DONE] = (s_reg.ch[g].count_reload == pdmae_pkg::ZERO_COUNT)
          && (s_reg.ch[g].count == pdmae_pkg::ZERO_COUNT);
      assign src[g][pdmae_pkg::INT_FAULT] = s_reg.ch[g].fault;
      assign irq_lines[g*3 +: 3] = src[g] & s_reg.ch[g].mask;
      // serve while enabled, not faulted and count non-zero
      assign eligible[g] = s_reg.ch[g].enabled && !s_reg.ch[g].fault
          && (s_reg.ch[g].count != pdmae_pkg::ZERO_COUNT)
          && (32'(id) < PERIPHS) && periph_req[id];
    end
  endgenerate

  pdmae_arbiter #(.N(CHANNELS)) u_arb (
    .request(eligible),
    .grant(grant),
    .any(grant_any)
  );

  always_comb
  begin
    grant_idx = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
      if (grant[i])
        grant_idx = CW'(i);
  end

  // ======================================================
  // Current channel views
  pdmae_pkg::pdmae_chan_t cc;
  logic [ID_BITS-1:0] cid;
  logic [31:0] step, wmask;
  assign cc = s_reg.ch[s_reg.cur];
  assign cid = cc.select[ID_BITS-1:0];

  always_comb
  begin
    unique case (cc.size)
      pdmae_pkg::SIZE_BYTE:
      begin
        step = pdmae_pkg::STEP_BYTE;
        wmask = pdmae_pkg::MASK_BYTE;
      end
      pdmae_pkg::SIZE_HALF:
      begin
        step = pdmae_pkg::STEP_HALF;
        wmask = pdmae_pkg::MASK_HALF;
      end
      default:
      begin
        // Reserved size treated as word
        step = pdmae_pkg::STEP_WORD;
        wmask = pdmae_pkg::MASK_WORD;
      end
    endcase
  end

  // ======================================================
  // Next state
  always_comb
  begin
    logic [5:0] o;
    logic [31:0] rd;
    o = ofs;
    rd = pdmae_pkg::ZERO_WORD;
    s_next = s_reg;
    s_next.ack = '0;

    unique case (s_reg.state)
      pdmae_pkg::ST_IDLE:
      begin
        if (grant_any)
        begin
          s_next.cur = grant_idx;
          s_next.state = pdmae_pkg::ST_MEM;
          // sized by granted channel, not cur
          s_next.data = periph_rdata & ((s_reg.ch[grant_idx].size == pdmae_pkg::SIZE_BYTE) ? pdmae_pkg::MASK_BYTE
              : (s_reg.ch[grant_idx].size == pdmae_pkg::SIZE_HALF) ? pdmae_pkg::MASK_HALF : pdmae_pkg::MASK_WORD);
        end
      end
      pdmae_pkg::ST_MEM:
      begin
        if (mem_done || mem_error)
        begin
          if (mem_error)
          begin
            s_next.ch[s_reg.cur].fault = 1'b1;
            s_next.state = pdmae_pkg::ST_IDLE;
          end
          else
          begin
            s_next.data = mem_rdata & wmask;
            s_next.state = pdmae_pkg::ST_ACK;
            s_next.ch[s_reg.cur].count = cc.count - pdmae_pkg::ONE_COUNT;
            s_next.ch[s_reg.cur].pointer = cc.pointer + step;
            if ((cc.count == pdmae_pkg::ONE_COUNT) && (cc.count_reload != pdmae_pkg::ZERO_COUNT))
            begin
              s_next.ch[s_reg.cur].count = cc.count_reload;
              s_next.ch[s_reg.cur].pointer = cc.pointer_reload;
              s_next.ch[s_reg.cur].count_reload = pdmae_pkg::ZERO_COUNT;
              s_next.ch[s_reg.cur].pointer_reload = pdmae_pkg::ZERO_WORD;
            end
          end
        end
      end
      pdmae_pkg::ST_ACK:
      begin
        if (32'(cid) < PERIPHS)
          s_next.ack[cid] = 1'b1;
        s_next.state = pdmae_pkg::ST_IDLE;
      end
    endcase

    // Register writes; engine updates of the same cycle give way, except a fault set
    if (acc && pwrite && ch_hit)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        if (32'(chsel) == c)
        begin
          unique case (o)
            pdmae_pkg::OFS_POINTER: s_next.ch[c].pointer = pwdata;
            pdmae_pkg::OFS_SELECT: s_next.ch[c].select = pwdata[7:0];
            pdmae_pkg::OFS_COUNT: s_next.ch[c].count = pwdata[15:0];
            pdmae_pkg::OFS_POINTER_RELOAD: s_next.ch[c].pointer_reload = pwdata;
            pdmae_pkg::OFS_COUNT_RELOAD:
            begin
              // direct load when live count empty
              if (s_next.ch[c].count == pdmae_pkg::ZERO_COUNT)
              begin
                s_next.ch[c].count = pwdata[15:0];
                s_next.ch[c].pointer = s_next.ch[c].pointer_reload;
                s_next.ch[c].count_reload = pdmae_pkg::ZERO_COUNT;
                s_next.ch[c].pointer_reload = pdmae_pkg::ZERO_WORD;
              end
              else
                s_next.ch[c].count_reload = pwdata[15:0];
            end
            pdmae_pkg::OFS_CONTROL:
            begin
              if (pwdata[pdmae_pkg::CTL_ENABLE_BIT])
                s_next.ch[c].enabled = 1'b1;
              if (pwdata[pdmae_pkg::CTL_DISABLE_BIT])
                s_next.ch[c].enabled = 1'b0;
              // fault clear, set in this cycle wins
              if (pwdata[pdmae_pkg::CTL_FAULT_CLEAR_BIT] && !s_next.ch[c].fault)
                s_next.ch[c].fault = 1'b0;
              else if (pwdata[pdmae_pkg::CTL_FAULT_CLEAR_BIT] && !(mem_error && s_reg.cur == CW'(c)
                  && s_reg.state == pdmae_pkg::ST_MEM))
                s_next.ch[c].fault = 1'b0;
            end
            pdmae_pkg::OFS_MODE: s_next.ch[c].size = pwdata[1:0];
            pdmae_pkg::OFS_INT_SET: s_next.ch[c].mask = s_next.ch[c].mask | pwdata[2:0];
            pdmae_pkg::OFS_INT_CLEAR: s_next.ch[c].mask = s_next.ch[c].mask & ~pwdata[2:0];
            default: ;
          endcase
        end
      end
    end

    // Reads: registered in the setup cycle of the transfer
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (32'(chsel) == c)
      begin
        unique case (o)
          pdmae_pkg::OFS_POINTER: rd = s_reg.ch[c].pointer;
          pdmae_pkg::OFS_SELECT: rd = {24'h00_0000, s_reg.ch[c].select};
          pdmae_pkg::OFS_COUNT: rd = {16'h0000, s_reg.ch[c].count};
          pdmae_pkg::OFS_POINTER_RELOAD: rd = s_reg.ch[c].pointer_reload;
          pdmae_pkg::OFS_COUNT_RELOAD: rd = {16'h0000, s_reg.ch[c].count_reload};
          pdmae_pkg::OFS_MODE: rd = {30'h0000_0000, s_reg.ch[c].size};
          pdmae_pkg::OFS_STATE: rd = {31'h0000_0000, s_reg.ch[c].enabled};
          pdmae_pkg::OFS_INT_MASK: rd = {29'h0000_0000, s_reg.ch[c].mask};
          pdmae_pkg::OFS_INT_STATUS: rd = {29'h0000_0000, src[c]};
          default: rd = pdmae_pkg::ZERO_WORD;
        endcase
      end
    end
    if (psel && !penable && !pwrite)
      s_next.prdata = ch_hit ? rd : pdmae_pkg::ZERO_WORD;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        s_reg.ch[c].pointer <= pdmae_pkg::ZERO_WORD;
        s_reg.ch[c].pointer_reload <= pdmae_pkg::ZERO_WORD;
        s_reg.ch[c].count <= pdmae_pkg::ZERO_COUNT;
        s_reg.ch[c].count_reload <= pdmae_pkg::ZERO_COUNT;
        s_reg.ch[c].select <= SELECT_RESET;
        s_reg.ch[c].size <= pdmae_pkg::SIZE_BYTE;
        s_reg.ch[c].enabled <= 1'b0;
        s_reg.ch[c].fault <= 1'b0;
        s_reg.ch[c].mask <= 3'h0;
      end
      s_reg.state <= pdmae_pkg::ST_IDLE;
      s_reg.cur <= '0;
      s_reg.data <= pdmae_pkg::ZERO_WORD;
      s_reg.prdata <= pdmae_pkg::ZERO_WORD;
      s_reg.ack <= '0;
    end
    else
      s_reg <= s_next;
  end

  // ======================================================
  // Outputs
  logic dir_cur;
  assign dir_cur = (32'(cid) < PERIPHS) ? periph_to_mem[cid] : 1'b0;
  assign pready = 1'b1;
  assign pslverr = acc && !ch_hit;
  assign prdata = s_reg.prdata;
  assign periph_ack = s_reg.ack;
  // identity gives direction, handshake and holding address
  assign periph_addr = (32'(cid) < PERIPHS) ? periph_holding_addr[32*cid +: 32] : pdmae_pkg::ZERO_WORD;
  assign periph_wdata = s_reg.data;
  assign periph_wstrobe = (s_reg.state == pdmae_pkg::ST_ACK) && !dir_cur;
  assign mem_valid = s_reg.state == pdmae_pkg::ST_MEM;
  assign mem_req.addr = cc.pointer;
  assign mem_req.write = dir_cur;
  assign mem_req.size = cc.size;
  assign mem_req.wdata = s_reg.data;

  // ======================================================
  // Checks
  sequence s_item_done;
    (s_reg.state == pdmae_pkg::ST_MEM) && mem_done && !mem_error;
  endsequence

  a_ack_follows_item: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_item_done |=> ##1 (periph_ack != '0)) else $error("No acknowledge after item");
  a_count_decrements: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_item_done and ((cc.count > pdmae_pkg::ONE_COUNT) && !(psel && pwrite))
    |=> s_reg.ch[$past(s_reg.cur)].count == $past(cc.count) - pdmae_pkg::ONE_COUNT)
    else $error("Count not decremented");
  a_pointer_steps: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_item_done and ((cc.count > pdmae_pkg::ONE_COUNT) && !(psel && pwrite))
    |=> s_reg.ch[$past(s_reg.cur)].pointer == $past(cc.pointer) + $past(step))
    else $error("Pointer step wrong");
  a_fault_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_reg.state == pdmae_pkg::ST_MEM) && mem_error
    |=> s_reg.ch[$past(s_reg.cur)].fault && (s_reg.state == pdmae_pkg::ST_IDLE))
    else $error("Fault not recorded");
  a_priority_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_reg.state == pdmae_pkg::ST_IDLE) && eligible[0] |=> s_reg.cur == '0)
    else $error("Channel zero not first");
  a_reload_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_item_done and ((cc.count == pdmae_pkg::ONE_COUNT) && (cc.count_reload != pdmae_pkg::ZERO_COUNT)
    && !(psel && pwrite)) |=> s_reg.ch[$past(s_reg.cur)].count_reload == pdmae_pkg::ZERO_COUNT)
    else $error("Reload not cleared");
  a_byte_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_reg.state == pdmae_pkg::ST_ACK) && (cc.size == pdmae_pkg::SIZE_BYTE)
    |-> periph_wdata[31:8] == 24'h00_0000) else $error("Byte data not masked");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_lines[pdmae_pkg::INT_DONE] |-> s_reg.ch[0].mask[pdmae_pkg::INT_DONE])
    else $error("Interrupt passed mask");
  a_fault_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_reg.ch[0].fault |-> !eligible[0]) else $error("Faulted channel served");
endmodule

// >>> rtl/pdmae_pkg.sv
// Package: register map, field layout and types of the peripheral DMA engine
package pdmae_pkg;
  localparam int unsigned CHAN_STRIDE_BITS = 6;
  localparam logic [5:0] OFS_POINTER = 6'h00;
  localparam logic [5:0] OFS_SELECT = 6'h04;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_POINTER_RELOAD = 6'h0c;
  localparam logic [5:0] OFS_COUNT_RELOAD = 6'h10;
  localparam logic [5:0] OFS_CONTROL = 6'h14;
  localparam logic [5:0] OFS_MODE = 6'h18;
  localparam logic [5:0] OFS_STATE = 6'h1c;
  localparam logic [5:0] OFS_INT_SET = 6'h20;
  localparam logic [5:0] OFS_INT_CLEAR = 6'h24;
  localparam logic [5:0] OFS_INT_MASK = 6'h28;
  localparam logic [5:0] OFS_INT_STATUS = 6'h2c;
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_DISABLE_BIT = 1;
  localparam int unsigned CTL_FAULT_CLEAR_BIT = 8;
  localparam int unsigned INT_RELOAD_EMPTY = 0;
  localparam int unsigned INT_DONE = 1;
  localparam int unsigned INT_FAULT = 2;
  localparam int unsigned INT_BITS = 3;
  localparam int unsigned COUNT_BITS = 16;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] STEP_WORD = 32'h0000_0004;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
  localparam logic [31:0] MASK_WORD = 32'hffff_ffff;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_COUNT = 16'h0000;
  localparam logic [15:0] ONE_COUNT = 16'h0001;

  typedef struct packed {
    logic [31:0] pointer;
    logic [31:0] pointer_reload;
    logic [15:0] count;
    logic [15:0] count_reload;
    logic [7:0] select;
    logic [1:0] size;
    logic enabled;
    logic fault;
    logic [2:0] mask;
  } pdmae_chan_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
  } pdmae_mem_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_ACK} pdmae_state_t;
endpackage
